// [hdl/jtss_tap.sv]
// boundary-scan test access port with identification, bypass, status and user
// data registers; user words cross to the system clock through a buffer
// assumes the host drives tck, tms and tdi, and the bench resolves the tdo pin
//
// Overview of operation
// RQ1 - sixteen-state controller, steps on rising tck, next state chosen by tms
// RQ2 - host reaches shift-ir and shifts instruction bits in serially on tdi
// RQ3 - host idles in run-test/idle after an instruction so it is latched
// RQ4 - data scans use the data branch exactly as instruction scans use theirs
// RQ5 - host sequencer offers instruction scan, data scan and idle operations
// RQ6 - least significant instruction bit enters tdi first
// RQ7 - host sets pause-ir end state and forces test-logic-reset before id read
// RQ8 - instruction register is ten bits; identify code is 1001101000 lsb first
// RQ9 - host idles at least 5 us and 3 tck cycles before the data scan
// RQ10 - identification read is a 32-bit data scan returned on tdo
// RQ11 - host reads configuration-complete status through the port
// RQ12 - tdi sampled on rising tck, tdo changes on falling, off when idle
// RQ13 - bypass passes tdi to tdo through one flip-flop
// RQ14 - five rising edges with tms high reach test-logic-reset from anywhere
`timescale 1ns/100ps
`default_nettype none
module jtss_tap #(
  parameter logic [31:0] ID_WORD = jtss_pkg::ID_WORD_DEFAULT
) (
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // link pins
  input wire logic i_tck_link,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // device status
  input wire logic i_configuration_complete_flag,
  // user words to system logic
  output logic o_word_valid,
  input wire logic i_word_ready,
  output jtss_pkg::jtss_word_t o_word
);
  import jtss_pkg::*;

  // ----------------------------------------------------------------------------
  // controller next-state decode
  // ----------------------------------------------------------------------------
  function automatic jtss_state_t tap_next(input jtss_state_t s, input logic tms);
    jtss_state_t n;
    n = st_reset;
    case (s)
      st_reset: n = tms ? st_reset : st_idle;
      st_idle: n = tms ? st_dr_select : st_idle;
      st_dr_select: n = tms ? st_ir_select : st_dr_capture;
      st_dr_capture: n = tms ? st_dr_exit1 : st_dr_shift;
      st_dr_shift: n = tms ? st_dr_exit1 : st_dr_shift;
      st_dr_exit1: n = tms ? st_dr_update : st_dr_pause;
      st_dr_pause: n = tms ? st_dr_exit2 : st_dr_pause;
      st_dr_exit2: n = tms ? st_dr_update : st_dr_shift;
      st_dr_update: n = tms ? st_dr_select : st_idle;
      st_ir_select: n = tms ? st_reset : st_ir_capture;
      st_ir_capture: n = tms ? st_ir_exit1 : st_ir_shift;
      st_ir_shift: n = tms ? st_ir_exit1 : st_ir_shift;
      st_ir_exit1: n = tms ? st_ir_update : st_ir_pause;
      st_ir_pause: n = tms ? st_ir_exit2 : st_ir_pause;
      st_ir_exit2: n = tms ? st_ir_update : st_ir_shift;
      st_ir_update: n = tms ? st_dr_select : st_idle;
      default: n = st_reset;
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------------------
  // link-domain and system-domain declarations
  // ----------------------------------------------------------------------------
  logic rst_l1;
  logic rst_l2;
  logic cfg_l1;
  logic cfg_l2;
  logic ack_l1;
  logic ack_l2;
  jtss_state_t state;
  jtss_state_t next_state;
  logic [9:0] ir;
  logic [9:0] ir_shift;
  logic [31:0] dr_shift;
  logic bypass_bit;
  logic status_bit;
  logic req_tgl;
  jtss_word_t xfer;
  logic sel_id;
  logic sel_stat;
  logic sel_user;
  logic sel_byp;
  logic shifting;
  logic tdo_mux;
  logic xfer_free;
  logic req_s1;
  logic req_s2;
  logic ack_s;
  logic pend;
  logic buf_in_ready;

  assign next_state = tap_next(state, i_tms); // RQ1
  assign sel_id = (ir == IDENTIFY_INSTRUCTION_VECTOR); // RQ8
  assign sel_stat = (ir == INSTR_STATUS);
  assign sel_user = (ir == INSTR_USER);
  assign sel_byp = !(sel_id || sel_stat || sel_user); // RQ13
  assign shifting = (state == st_dr_shift) || (state == st_ir_shift);
  assign xfer_free = (req_tgl == ack_l2);
  assign tdo_mux = (state == st_ir_shift) ? ir_shift[0] :
                   sel_stat ? status_bit :
                   sel_byp ? bypass_bit : dr_shift[0];

  // ----------------------------------------------------------------------------
  // link-domain synchronisers (reset, status flag, return toggle)
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_tck_link) begin
    rst_l1 <= i_rst;
    rst_l2 <= rst_l1;
    cfg_l1 <= i_configuration_complete_flag;
    cfg_l2 <= cfg_l1;
    ack_l1 <= ack_s;
    ack_l2 <= ack_l1;
  end

  // ----------------------------------------------------------------------------
  // controller and instruction register
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_tck_link) begin
    if (rst_l2) begin
      state <= st_reset;
    end else begin
      state <= next_state; // RQ14
    end
  end

  always_ff @(posedge i_tck_link) begin
    if (rst_l2 || state == st_reset) begin
      ir <= IDENTIFY_INSTRUCTION_VECTOR;
      ir_shift <= IR_CAPTURE_VAL;
    end else begin
      case (state)
        st_ir_capture: ir_shift <= IR_CAPTURE_VAL;
        st_ir_shift: ir_shift <= {i_tdi, ir_shift[9:1]}; // RQ6 RQ12
        st_ir_update: ir <= ir_shift; // RQ3 RQ8
        default: ir_shift <= ir_shift;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_tck_link) begin
    if (rst_l2) begin
      dr_shift <= DR_RESET_VAL;
      bypass_bit <= 1'b0;
      status_bit <= 1'b0;
    end else if (state == st_dr_capture) begin
      dr_shift <= sel_id ? ID_WORD : USER_CAPTURE_VAL; // RQ10
      bypass_bit <= 1'b0;
      status_bit <= cfg_l2; // RQ11
    end else if (state == st_dr_shift) begin
      dr_shift <= {i_tdi, dr_shift[31:1]}; // RQ4 RQ10
      bypass_bit <= i_tdi; // RQ13
      status_bit <= i_tdi;
    end
  end

  // user word handed off only when the previous one has been taken
  always_ff @(posedge i_tck_link) begin
    if (rst_l2) begin
      req_tgl <= 1'b0;
      xfer <= '0;
    end else if (state == st_dr_update && sel_user && xfer_free) begin
      xfer <= '{instr: ir, data: dr_shift};
      req_tgl <= ~req_tgl;
    end
  end

  // ----------------------------------------------------------------------------
  // output pin, updated on falling tck
  // ----------------------------------------------------------------------------
  always_ff @(negedge i_tck_link) begin
    if (rst_l2) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo <= tdo_mux; // RQ12
      o_tdo_oe <= shifting; // RQ12
    end
  end

  // ----------------------------------------------------------------------------
  // system-domain side of the handshake
  // ----------------------------------------------------------------------------
  assign pend = (req_s2 != ack_s);

  always_ff @(posedge i_clk_sys) begin
    req_s1 <= req_tgl;
    req_s2 <= req_s1;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ack_s <= 1'b0;
    end else if (pend && buf_in_ready) begin
      ack_s <= req_s2;
    end
  end

  jtss_buf #(
    .WIDTH(WORD_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_in_valid(pend),
    .o_in_ready(buf_in_ready),
    .i_in_data(xfer),
    .o_out_valid(o_word_valid),
    .i_out_ready(i_word_ready),
    .o_out_data(o_word)
  );

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  sequence s_tms_high_run;
    i_tms [*5];
  endsequence

  property p_five_tms_reset;
    @(posedge i_tck_link) disable iff (rst_l2)
      s_tms_high_run |=> (state == st_reset);
  endproperty
  a_five_tms_reset: assert property (p_five_tms_reset) else $error("no reset after tms run"); // RQ14

  property p_leave_reset;
    @(posedge i_tck_link) disable iff (rst_l2)
      (state == st_reset && !i_tms) |=> (state == st_idle) && (ir == IDENTIFY_INSTRUCTION_VECTOR);
  endproperty
  a_leave_reset: assert property (p_leave_reset) else $error("reset exit wrong"); // RQ1

  property p_ir_shift_order;
    @(posedge i_tck_link) disable iff (rst_l2)
      (state == st_ir_shift) |=> (ir_shift[9] == $past(i_tdi)) && (ir_shift[8:0] == $past(ir_shift[9:1]));
  endproperty
  a_ir_shift_order: assert property (p_ir_shift_order) else $error("ir shift order wrong"); // RQ6

  property p_ir_update;
    @(posedge i_tck_link) disable iff (rst_l2)
      (state == st_ir_update) |=> (ir == $past(ir_shift));
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("ir not latched on update"); // RQ8

  property p_id_capture;
    @(posedge i_tck_link) disable iff (rst_l2)
      (state == st_dr_capture && sel_id) |=> (dr_shift == ID_WORD);
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("id word not captured"); // RQ10

  sequence s_bypass_two_shifts;
    (state == st_dr_shift && sel_byp) ##1 (state == st_dr_shift);
  endsequence

  property p_bypass_one_stage;
    @(posedge i_tck_link) disable iff (rst_l2)
      s_bypass_two_shifts |-> (bypass_bit == $past(i_tdi)) ##0 (tdo_mux == bypass_bit);
  endproperty
  a_bypass_one_stage: assert property (p_bypass_one_stage) else $error("bypass delay wrong"); // RQ13

  property p_tdo_off_idle;
    @(negedge i_tck_link) disable iff (rst_l2)
      (state == st_idle) |=> !o_tdo_oe;
  endproperty
  a_tdo_off_idle: assert property (p_tdo_off_idle) else $error("tdo driven while idle"); // RQ12

  property p_status_capture;
    @(posedge i_tck_link) disable iff (rst_l2)
      (state == st_dr_capture) |=> (status_bit == $past(cfg_l2));
  endproperty
  a_status_capture: assert property (p_status_capture) else $error("status not captured"); // RQ11

  property p_tdo_on_shift;
    @(negedge i_tck_link) disable iff (rst_l2)
      shifting |=> o_tdo_oe;
  endproperty
  a_tdo_on_shift: assert property (p_tdo_on_shift) else $error("tdo off in shift"); // RQ12

  property p_tdo_mux_out;
    @(negedge i_tck_link) disable iff (rst_l2)
      shifting |=> (o_tdo == $past(tdo_mux));
  endproperty
  a_tdo_mux_out: assert property (p_tdo_mux_out) else $error("tdo source wrong"); // RQ12

  property p_dr_shift_in;
    @(posedge i_tck_link) disable iff (rst_l2)
      (state == st_dr_shift) |=> (dr_shift[31] == $past(i_tdi));
  endproperty
  a_dr_shift_in: assert property (p_dr_shift_in) else $error("dr shift input wrong"); // RQ10

  property p_ack_returns;
    @(posedge i_clk_sys) disable iff (i_rst)
      (pend && buf_in_ready) |=> !pend [*2];
  endproperty
  a_ack_returns: assert property (p_ack_returns) else $error("handshake ack missing");

endmodule // jtss_tap
`default_nettype wire

// [hdl/jtss_pkg.sv]
// test access port package: instruction codes, capture values, states, carrier
// assumes nothing beyond a SystemVerilog compiler
package jtss_pkg;

  // ----------------------------------------------------------------------------
  // register widths and reset edge count
  // ----------------------------------------------------------------------------
  localparam int unsigned IR_WIDTH = 10;
  localparam int unsigned DR_WIDTH = 32;
  localparam int unsigned RST_TMS_EDGES = 5;

  // ----------------------------------------------------------------------------
  // instruction codes, written msb..lsb
  // ----------------------------------------------------------------------------
  // 1001101000 read lsb first gives bit0=1 ... bit9=0
  localparam logic [9:0] IDENTIFY_INSTRUCTION_VECTOR = 10'h059;
  localparam logic [9:0] INSTR_BYPASS = 10'h3ff;
  localparam logic [9:0] INSTR_STATUS = 10'h001;
  localparam logic [9:0] INSTR_USER = 10'h002;
  // fixed pattern loaded into the instruction shifter on capture
  localparam logic [9:0] IR_CAPTURE_VAL = 10'h001;

  // ----------------------------------------------------------------------------
  // capture and reset values
  // ----------------------------------------------------------------------------
  // identification word: value is arbitrary, lsb set as the scan standard asks
  localparam logic [31:0] ID_WORD_DEFAULT = 32'h0a5a_5001;
  localparam logic [31:0] USER_CAPTURE_VAL = 32'h0000_0000;
  localparam logic [31:0] DR_RESET_VAL = 32'h0000_0000;

  // ----------------------------------------------------------------------------
  // buffer
  // ----------------------------------------------------------------------------
  localparam int unsigned BUF_DEPTH = 2;

  typedef enum logic [3:0] {
    st_reset, st_idle, st_dr_select, st_dr_capture, st_dr_shift, st_dr_exit1,
    st_dr_pause, st_dr_exit2, st_dr_update, st_ir_select, st_ir_capture,
    st_ir_shift, st_ir_exit1, st_ir_pause, st_ir_exit2, st_ir_update
  } jtss_state_t;

  // word handed from the link to the system side after a user data update
  typedef struct packed {
    logic [9:0] instr;
    logic [31:0] data;
  } jtss_word_t;

  localparam int unsigned WORD_BITS = $bits(jtss_word_t);

endpackage

// [hdl/jtss_buf.sv]
// shift-style buffer whose head entry is a flip-flop
// assumes a single clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module jtss_buf #(
  parameter int unsigned WIDTH = jtss_pkg::WORD_BITS,
  parameter int unsigned DEPTH = jtss_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  import jtss_pkg::*;

  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;
  logic [CW-1:0] wr_slot;

  assign o_in_ready = (count != FULL_CNT);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[0];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign next_count = count + CW'(push) - CW'(pop);
  assign wr_slot = pop ? count - CW'(1) : count;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------------------
  // storage: shift toward the head on pop, write behind the last entry
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_slot
      always_ff @(posedge i_clk_sys) begin
        if (push && (wr_slot == CW'(g))) begin
          mem[g] <= i_in_data;
        end else if (pop && (g + 1 < DEPTH)) begin
          mem[g] <= mem[(g + 1) % DEPTH];
        end
      end
    end
  endgenerate

  property p_full_refuses;
    @(posedge i_clk_sys) disable iff (i_rst)
      (count == FULL_CNT && !i_out_ready) |=> !o_in_ready && (count == FULL_CNT);
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("buffer lost a full state");

endmodule // jtss_buf
`default_nettype wire

// [tb/jtss_host.sv]
// host model: drives test clock, mode select and data in; samples data out
// assumes a pull-up on the data-out wire; test clock stands still between tasks
`timescale 1ns/100ps
`default_nettype none
module jtss_host (
  // link pins
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  logic pin;
  // ----------------------------------------------------------------------------
  // wire level, pulled up when released
  // ----------------------------------------------------------------------------
  assign pin = i_tdo_oe ? i_tdo : 1'b1;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // ----------------------------------------------------------------------------
  // one test clock: set up, sample before rising edge, then clock
  // ----------------------------------------------------------------------------
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #7.5 tdo = pin;
    o_tck = 1'b1;
    #7.5 o_tck = 1'b0;
  endtask
  // five mode-select highs, then on to idle
  task automatic tlr();
    logic d;
    repeat (5) tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
  endtask
  task automatic idle(input int n);
    logic d;
    repeat (n) tick(1'b0, 1'b1, d);
  endtask
  // scan from idle, back to idle; optional stop in pause before update
  task automatic scan(input bit ir, input int n, input logic [31:0] din, input bit pause,
                      output logic [31:0] dout);
    logic d;
    int i;
    dout = '0;
    tick(1'b1, 1'b1, d);
    if (ir) tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
    tick(1'b0, 1'b1, d);
    for (i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    if (pause) begin
      tick(1'b0, 1'b1, d);
      tick(1'b1, 1'b1, d);
    end
    tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
  endtask
endmodule // jtss_host
`default_nettype wire

// [tb/jtss_tap_bench.sv]
// self-checking bench for the test access port
// assumes the host model in jtss_host and the design package
`timescale 1ns/100ps
`default_nettype none
module jtss_tap_bench;
  import jtss_pkg::*;
  logic clk, rst, tck, tms, tdi, tdo, tdo_oe, flag, wvalid, wready;
  jtss_word_t word;
  int err_count = 0;
  int compares = 0;
  // ----------------------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------------------
  jtss_tap dut (.i_clk_sys(clk), .i_rst(rst), .i_tck_link(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_configuration_complete_flag(flag),
    .o_word_valid(wvalid), .i_word_ready(wready), .o_word(word));
  jtss_host host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------------------
  task automatic check(input string what, input logic [41:0] seen, input logic [41:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_valid();
    int n;
    n = 0;
    while (wvalid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (wvalid !== 1'b1) begin
      $display("unexpected word valid: expected 1 seen 0");
      err_count++;
      end_sim();
    end
  endtask
  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic test_idcode();
    logic [31:0] d;
    logic b;
    host.scan(1, 10, {22'h0, INSTR_BYPASS}, 0, d);
    host.tick(1'b1, 1'b1, b);
    host.tick(1'b0, 1'b1, b);
    host.tick(1'b0, 1'b1, b);
    host.tlr();
    host.scan(0, 32, 32'hffff_ffff, 0, d);
    check("id after mode reset", d, ID_WORD_DEFAULT);
    host.tlr();
    host.scan(1, 10, {22'h0, IDENTIFY_INSTRUCTION_VECTOR}, 1, d);
    check("ir capture", d, IR_CAPTURE_VAL);
    host.idle(334);
    host.scan(0, 32, 32'hffff_ffff, 0, d);
    check("id word", d, ID_WORD_DEFAULT);
    @(negedge clk);
    check("tdo enable in idle", tdo_oe, 1'b0);
    $display("test idcode done");
  endtask
  task automatic test_bypass();
    logic [31:0] d;
    host.scan(1, 10, {22'h0, INSTR_BYPASS}, 0, d);
    host.scan(0, 8, 32'h0000_00b5, 0, d);
    check("bypass out", d, 32'h0000_006a);
    $display("test bypass done");
  endtask
  task automatic test_status();
    logic [31:0] d;
    int f;
    for (f = 0; f < 2; f++) begin
      @(negedge clk);
      flag = f[0];
      host.idle(4);
      host.scan(1, 10, {22'h0, INSTR_STATUS}, 0, d);
      host.scan(0, 1, 32'h0, 0, d);
      check("config status", d, {31'h0, f[0]});
    end
    $display("test status done");
  endtask
  task automatic test_words();
    logic [31:0] d;
    int k;
    host.scan(1, 10, {22'h0, INSTR_USER}, 0, d);
    for (k = 0; k < 3; k++) begin
      host.scan(0, 32, 32'hc3a5_0f10 + k, 0, d);
      host.idle(4);
    end
    for (k = 0; k < 3; k++) begin
      wait_valid();
      check("user word", word, {INSTR_USER, 32'hc3a5_0f10 + k});
      wready = 1'b1;
      @(negedge clk);
      wready = 1'b0;
      repeat (8) @(negedge clk);
    end
    check("buffer empty", wvalid, 1'b0);
    $display("test words done");
  endtask
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    flag = 1'b1;
    wready = 1'b0;
    fork
      begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
      end
      host.tlr();
    join
    host.tlr();
    test_idcode();
    test_bypass();
    test_status();
    test_words();
    end_sim();
  end
endmodule // jtss_tap_bench
`default_nettype wire
